// File: rtl/hcp_i2c_slave.sv
// Two-wire serial slave with 16-bit register addressing
`timescale 1ns/1ps
module hcp_i2c_slave import hcp_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic addr_sel_i,
   output logic sda_oe_o,
   // Register side
   output logic wr_stb_o,
   output logic [15:0] addr_o,
   output logic [15:0] wdata_o,
   input wire logic [15:0] rdata_i
);

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_ADDR = 7'h02,
      S_ACK_A = 7'h04,
      S_RX = 7'h08,
      S_ACK_RX = 7'h10,
      S_TX = 7'h20,
      S_ACK_TX = 7'h40
   } hcp_i2c_state_type;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] sel_sync;
   logic scl_q;
   logic sda_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         sel_sync <= 2'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         sel_sync <= {sel_sync[0], addr_sel_i};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic start;
   logic stop;
   logic rise;
   logic fall;
   logic [6:0] own_addr;
   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   assign start = scl_s && scl_q && sda_q && !sda_s;
   assign stop = scl_s && scl_q && !sda_q && sda_s;
   assign rise = scl_s && !scl_q;
   assign fall = !scl_s && scl_q;
   assign own_addr = sel_sync[1] ? SLV_ADDR_HIGH : SLV_ADDR_LOW;

   // ----------------------------------------
   // Byte engine
   // ----------------------------------------
   // Oversampling at the system clock; a 400 kHz bus leaves 250 cycles per bit
   hcp_i2c_state_type state;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic [7:0] tx_lo;
   logic [1:0] phase;
   logic rw;
   logic lo_next;
   logic nack;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         tx_lo <= 8'h00;
         phase <= 2'h0;
         rw <= 1'b0;
         lo_next <= 1'b0;
         nack <= 1'b0;
         sda_oe_o <= 1'b0;
         wr_stb_o <= 1'b0;
         addr_o <= 16'h0000;
         wdata_o <= 16'h0000;
      end else begin
         wr_stb_o <= 1'b0;
         if (wr_stb_o) begin
            addr_o <= addr_o + ADDR_STEP;
         end
         if (start) begin
            state <= S_ADDR;
            cnt <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop) begin
            state <= S_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            unique case (state)
               S_IDLE: state <= S_IDLE;
               S_ADDR, S_RX: begin
                  if (rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt <= cnt + 4'h1;
                  end else if (fall && cnt == BYTE_BITS) begin
                     if (state == S_ADDR) begin
                        // Foreign address: stay off the bus until next start
                        if (shreg[7:1] == own_addr) begin
                           state <= S_ACK_A;
                           sda_oe_o <= 1'b1;
                           rw <= shreg[0];
                           phase <= 2'h0;
                        end else begin
                           state <= S_IDLE;
                        end
                     end else begin
                        state <= S_ACK_RX;
                        sda_oe_o <= 1'b1;
                        unique case (phase)
                           2'h0: begin
                              addr_o[15:8] <= shreg;
                              phase <= 2'h1;
                           end
                           2'h1: begin
                              addr_o[7:0] <= shreg;
                              phase <= 2'h2;
                           end
                           2'h2: begin
                              wdata_o[15:8] <= shreg;
                              phase <= 2'h3;
                           end
                           2'h3: begin
                              wdata_o[7:0] <= shreg;
                              wr_stb_o <= 1'b1;
                              phase <= 2'h2;
                           end
                        endcase
                     end
                  end
               end
               S_ACK_A: begin
                  if (fall) begin
                     cnt <= 4'h0;
                     if (rw) begin
                        state <= S_TX;
                        shreg <= rdata_i[15:8];
                        tx_lo <= rdata_i[7:0];
                        lo_next <= 1'b1;
                        sda_oe_o <= !rdata_i[15];
                     end else begin
                        state <= S_RX;
                        sda_oe_o <= 1'b0;
                     end
                  end
               end
               S_ACK_RX: begin
                  if (fall) begin
                     state <= S_RX;
                     cnt <= 4'h0;
                     sda_oe_o <= 1'b0;
                  end
               end
               S_TX: begin
                  if (fall) begin
                     if (cnt == TX_LAST_BIT) begin
                        state <= S_ACK_TX;
                        sda_oe_o <= 1'b0;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe_o <= !shreg[6];
                        cnt <= cnt + 4'h1;
                     end
                  end
               end
               S_ACK_TX: begin
                  if (rise) begin
                     nack <= sda_s;
                  end else if (fall) begin
                     cnt <= 4'h0;
                     if (nack) begin
                        state <= S_IDLE;
                     end else if (lo_next) begin
                        state <= S_TX;
                        shreg <= tx_lo;
                        sda_oe_o <= !tx_lo[7];
                        lo_next <= 1'b0;
                        addr_o <= addr_o + ADDR_STEP;
                     end else begin
                        state <= S_TX;
                        shreg <= rdata_i[15:8];
                        tx_lo <= rdata_i[7:0];
                        sda_oe_o <= !rdata_i[15];
                        lo_next <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

endmodule // hcp_i2c_slave

// File: pkg/hcp_pkg.sv
// Shared constants for the host command doorbell port
package hcp_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [15:0] CMD_ADDR = 16'h0040;
   localparam logic [15:0] POOL_ADDR = 16'hFC00;
   localparam logic [15:0] ADDR_STEP = 16'h0002;
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] POOL_RESET = 16'h0000;
   localparam int DOORBELL_BIT = 15;
   localparam logic [14:0] RESULT_BAD_CMD = 15'h0001;

   // ----------------------------------------
   // Two-wire slave
   // ----------------------------------------
   localparam logic [6:0] SLV_ADDR_LOW = 7'h48;
   localparam logic [6:0] SLV_ADDR_HIGH = 7'h5D;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;

   // ----------------------------------------
   // Command codes and state codes
   // ----------------------------------------
   localparam logic [15:0] SYS_SET_STATE = 16'h8100;
   localparam logic [15:0] SYS_GET_STATE = 16'h8101;
   localparam logic [15:0] OVL_FIRST = 16'h8200;
   localparam logic [15:0] OVL_LOAD_BUFFER = 16'h8206;
   localparam logic [15:0] OVL_LOAD_STATUS = 16'h8207;
   localparam logic [15:0] OVL_LOAD_STRING = 16'h820E;
   localparam logic [15:0] OVL_LAST = 16'h820E;
   localparam logic [15:0] GPIO_FIRST = 16'h8400;
   localparam logic [15:0] GPIO_BIND_INPUT = 16'h8404;
   localparam logic [15:0] GPIO_LAST = 16'h8405;
   localparam logic [15:0] STATE_APPLY_CONFIG = 16'h2800;

endpackage

// File: rtl/hcp_host_cmd_port.sv
// Host command doorbell port: command register, parameter pool, decode
`timescale 1ns/1ps
// Functional notes
// - Registers reached over two-wire bus, 400 kHz
// - Bit 15 command write rings doorbell
// - Completion clears doorbell, leaves result status
// - Zero result means success, nonzero failure
// - Response parameters in pool after completion
// - Pool at 0xFC00, command at 0x0040
// - System state set/get codes, synchronous
// - Overlay codes 0x8200 to 0x820E decoded
// - Load buffer asynchronous, load status synchronous
// - GPIO codes 0x8400 to 0x8405, synchronous
// - Code 0x8404 binds input to sequence
// - Each code classed synchronous or asynchronous
// - Memory commands by DMA run alike
module hcp_host_cmd_port import hcp_pkg::*; #(
   parameter int POOL_WORDS = 16
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // Two-wire bus pins
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic SADDR_I,
   // Processor side
   output logic DOORBELL_IRQ_O,
   output logic [15:0] CMD_CODE_O,
   output logic CMD_KNOWN_O,
   output logic CMD_ASYNC_O,
   output logic CMD_GPI_BIND_O,
   output logic CMD_APPLY_CFG_O,
   input wire logic FW_DONE_I,
   input wire logic [14:0] FW_RESULT_I,
   input wire logic FW_POOL_WE_I,
   input wire logic [$clog2(POOL_WORDS)-1:0] FW_POOL_IDX_I,
   input wire logic [15:0] FW_POOL_DATA_I,
   output logic [15:0] FW_POOL_RDATA_O,
   // Command DMA from memory
   input wire logic DMA_CMD_VALID_I,
   input wire logic [15:0] DMA_CMD_I,
   output logic DMA_CMD_READY_O
);

   localparam int PW = $clog2(POOL_WORDS);

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic wr_stb;
   logic [15:0] bus_addr;
   logic [15:0] bus_wdata;
   logic [15:0] bus_rdata;

   hcp_i2c_slave u_slave (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .scl_i(SCL_I),
      .sda_i(SDA_I),
      .addr_sel_i(SADDR_I),
      .sda_oe_o(SDA_OE_O),
      .wr_stb_o(wr_stb),
      .addr_o(bus_addr),
      .wdata_o(bus_wdata),
      .rdata_i(bus_rdata)
   );
   // Open drain: only ever pulls low
   assign SDA_O = 1'b0;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic is_known(input logic [15:0] c);
      return (c >= SYS_SET_STATE && c <= SYS_GET_STATE)
         || (c >= OVL_FIRST && c <= OVL_LAST)
         || (c >= GPIO_FIRST && c <= GPIO_LAST);
   endfunction

   function automatic logic is_async(input logic [15:0] c);
      return c == OVL_LOAD_BUFFER || c == OVL_LOAD_STRING;
   endfunction

   // ----------------------------------------
   // Command register
   // ----------------------------------------
   logic [15:0] cmd_reg;
   logic [15:0] pool [POOL_WORDS];
   logic busy;
   logic host_cmd_wr;
   logic host_issue;
   logic dma_issue;
   logic issue;
   logic auto_fail;
   logic [15:0] issue_code;
   logic pool_hit;
   logic [PW-1:0] pool_idx;

   assign busy = cmd_reg[DOORBELL_BIT];
   assign host_cmd_wr = wr_stb && bus_addr == CMD_ADDR;
   assign host_issue = host_cmd_wr && bus_wdata[DOORBELL_BIT] && !busy;
   // Host wins a tie; the sequencer simply retries next cycle
   assign DMA_CMD_READY_O = !busy && !host_cmd_wr;
   assign dma_issue = DMA_CMD_VALID_I && DMA_CMD_I[DOORBELL_BIT] && DMA_CMD_READY_O;
   assign issue = host_issue || dma_issue;
   assign issue_code = host_issue ? bus_wdata : DMA_CMD_I;
   // Undecoded codes finish at once so a host never hangs on them
   assign auto_fail = busy && !CMD_KNOWN_O;

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         cmd_reg <= CMD_RESET;
      end else if (issue) begin
         cmd_reg <= issue_code;
      end else if (busy && FW_DONE_I) begin
         cmd_reg <= {1'b0, FW_RESULT_I};
      end else if (auto_fail) begin
         cmd_reg <= {1'b0, RESULT_BAD_CMD};
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         CMD_KNOWN_O <= 1'b0;
         CMD_ASYNC_O <= 1'b0;
         CMD_GPI_BIND_O <= 1'b0;
         CMD_APPLY_CFG_O <= 1'b0;
      end else if (issue) begin
         CMD_KNOWN_O <= is_known(issue_code);
         CMD_ASYNC_O <= is_async(issue_code);
         CMD_GPI_BIND_O <= issue_code == GPIO_BIND_INPUT;
         CMD_APPLY_CFG_O <= issue_code == SYS_SET_STATE && pool[0] == STATE_APPLY_CONFIG;
      end
   end

   assign DOORBELL_IRQ_O = busy;
   assign CMD_CODE_O = cmd_reg;

   // ----------------------------------------
   // Parameter pool
   // ----------------------------------------
   assign pool_hit = bus_addr[15:PW+1] == POOL_ADDR[15:PW+1] && !bus_addr[0];
   assign pool_idx = bus_addr[PW:1];

   // Host writes while busy are not blocked; the host must hold off
   for (genvar i = 0; i < POOL_WORDS; i++) begin : g_pool
      always_ff @(posedge SYS_CLK_I) begin
         if (RST_I) begin
            pool[i] <= POOL_RESET;
         end else if (FW_POOL_WE_I && FW_POOL_IDX_I == PW'(i)) begin
            pool[i] <= FW_POOL_DATA_I;
         end else if (wr_stb && pool_hit && pool_idx == PW'(i)) begin
            pool[i] <= bus_wdata;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         FW_POOL_RDATA_O <= POOL_RESET;
      end else begin
         FW_POOL_RDATA_O <= pool[FW_POOL_IDX_I];
      end
   end

   always_comb begin
      bus_rdata = RD_UNMAPPED;
      if (bus_addr == CMD_ADDR) begin
         bus_rdata = cmd_reg;
      end else if (pool_hit) begin
         bus_rdata = pool[pool_idx];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   a_doorbell_ring: assert property (
      host_issue |=> DOORBELL_IRQ_O && CMD_CODE_O == $past(bus_wdata))
      else $error("command write did not ring doorbell");
   a_busy_keep: assert property (
      (host_cmd_wr && busy && CMD_KNOWN_O && !FW_DONE_I) |=> cmd_reg == $past(cmd_reg))
      else $error("busy command disturbed by write");
   a_done_result: assert property (
      (busy && FW_DONE_I && !issue) |=> !DOORBELL_IRQ_O
         && cmd_reg[DOORBELL_BIT-1:0] == $past(FW_RESULT_I))
      else $error("completion did not leave result");
   a_unknown_fails: assert property (
      (issue && !is_known(issue_code)) ##1 !FW_DONE_I |=> !DOORBELL_IRQ_O
         && cmd_reg[DOORBELL_BIT-1:0] == RESULT_BAD_CMD)
      else $error("unknown command not failed");
   a_load_async: assert property (
      (issue && issue_code == OVL_LOAD_BUFFER) |=> CMD_ASYNC_O && CMD_KNOWN_O)
      else $error("load buffer not asynchronous");
   a_state_sync: assert property (
      (issue && issue_code == SYS_SET_STATE) |=> CMD_KNOWN_O && !CMD_ASYNC_O)
      else $error("set state misclassed");
   a_gpio_bind: assert property (
      (issue && issue_code == GPIO_BIND_INPUT) |=> CMD_GPI_BIND_O && !CMD_ASYNC_O)
      else $error("input bind not flagged");
   a_dma_issue: assert property (
      dma_issue |=> DOORBELL_IRQ_O && CMD_CODE_O == $past(DMA_CMD_I))
      else $error("memory command not issued");
   a_pool_resp: assert property (
      FW_POOL_WE_I |=> pool[$past(FW_POOL_IDX_I)] == $past(FW_POOL_DATA_I))
      else $error("response parameter not stored");

   c_host_cmd: cover property (host_issue ##[1:300] !DOORBELL_IRQ_O);
   c_dma_cmd: cover property (dma_issue);
   c_bad_cmd: cover property (issue && !is_known(issue_code));
   c_busy_write: cover property (host_cmd_wr && busy);

endmodule // hcp_host_cmd_port

// File: sim/hcp_host_model.sv
// Two-wire bus host model that drives the command port
`timescale 1ns/1ps
module hcp_host_model import hcp_pkg::*; #(
   parameter int QTR = 63
) (
   // Clock
   input wire logic clk_i,
   // Bus lines
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // ----------------------------------------
   // Bit and byte level
   // ----------------------------------------
   // Four quarters of 63 cycles give 396.8 kHz, just under the top rate
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wq();
      repeat (QTR) @(negedge clk_i);
   endtask
   // SDA moves only while SCL is low
   task automatic bit_io(input logic bo, output logic bi);
      sda_low_o = !bo;
      wq();
      scl_o = 1'b1;
      wq();
      bi = sda_i;
      wq();
      scl_o = 1'b0;
      wq();
   endtask
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                       output logic ackd);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], b);
         rx[i] = b;
      end
      bit_io(last, b);
      ackd = !b;
   endtask
   // Also serves as repeated start, since it releases SDA while SCL is still low, then raises SCL
   task automatic start();
      sda_low_o = 1'b0;
      wq();
      scl_o = 1'b1;
      wq();
      sda_low_o = 1'b1;
      wq();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      wq();
      scl_o = 1'b1;
      wq();
      sda_low_o = 1'b0;
      wq();
   endtask
   // ----------------------------------------
   // Register level
   // ----------------------------------------
   task automatic probe(input logic [7:0] sa, output logic ackd);
      logic [7:0] rx;
      start();
      xfer(sa, 1'b1, rx, ackd);
      stop();
   endtask
   // Only command and pool words are touched, hi byte first
   task automatic reg_wr(input logic [15:0] a, input logic [15:0] d, output int nacks);
      logic [7:0] by [5];
      logic [7:0] rx;
      logic k;
      by = '{{SLV_ADDR_LOW, 1'b0}, a[15:8], a[7:0], d[15:8], d[7:0]};
      nacks = 0;
      start();
      for (int i = 0; i < 5; i++) begin
         xfer(by[i], 1'b1, rx, k);
         nacks += int'(!k);
      end
      stop();
   endtask
   task automatic reg_rd(input logic [15:0] a, output logic [15:0] w0, output logic [15:0] w1,
                         output int nacks);
      logic [7:0] by [4];
      logic [7:0] rx [4];
      logic k;
      by = '{{SLV_ADDR_LOW, 1'b0}, a[15:8], a[7:0], {SLV_ADDR_LOW, 1'b1}};
      nacks = 0;
      start();
      for (int i = 0; i < 4; i++) begin
         if (i == 3) start();
         xfer(by[i], 1'b1, rx[0], k);
         nacks += int'(!k);
      end
      // Last byte is not acknowledged, ending the read
      for (int i = 0; i < 4; i++) xfer(8'hFF, i == 3, rx[i], k);
      stop();
      w0 = {rx[0], rx[1]};
      w1 = {rx[2], rx[3]};
   endtask
endmodule // hcp_host_model

// File: sim/tb_top.sv
// Self-checking bench for the host command doorbell port
`timescale 1ns/1ps
module tb_top import hcp_pkg::*; ();
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl, host_low, sda_oe, sda_out, irq, known, async_f, bind_f, apply_f, ready, ack;
   logic done = 1'b0;
   logic saddr = 1'b0;
   logic pwe = 1'b0;
   logic dvalid = 1'b0;
   logic [3:0] pidx = 4'h0;
   logic [14:0] result = 15'h0000;
   logic [15:0] pdata = 16'h0000;
   logic [15:0] dword = 16'h0000;
   logic [15:0] code, pool_rd, m_cmd, w0, w1;
   logic [15:0] m_pool [16];
   logic [15:0] codes [$];
   int n_errors = 0;
   int checked = 0;
   int nk;
   // Open drain line with pull-up
   wire sda = !(host_low | sda_oe);
   always #5 clk = ~clk;
   hcp_host_cmd_port #(.POOL_WORDS(16)) u_dut (
      .SYS_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out),
      .SDA_OE_O(sda_oe), .SADDR_I(saddr), .DOORBELL_IRQ_O(irq), .CMD_CODE_O(code),
      .CMD_KNOWN_O(known), .CMD_ASYNC_O(async_f), .CMD_GPI_BIND_O(bind_f),
      .CMD_APPLY_CFG_O(apply_f), .FW_DONE_I(done), .FW_RESULT_I(result),
      .FW_POOL_WE_I(pwe), .FW_POOL_IDX_I(pidx), .FW_POOL_DATA_I(pdata),
      .FW_POOL_RDATA_O(pool_rd), .DMA_CMD_VALID_I(dvalid), .DMA_CMD_I(dword),
      .DMA_CMD_READY_O(ready));
   hcp_host_model u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
   // ----------------------------------------
   // Checking and reference model
   // ----------------------------------------
   task automatic give_verdict();
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [2:0] flags(input logic [15:0] c);
      logic kn;
      kn = c == SYS_SET_STATE || c == SYS_GET_STATE || (c >= OVL_FIRST && c <= OVL_LAST)
           || (c >= GPIO_FIRST && c <= GPIO_LAST);
      return {kn, c == OVL_LOAD_BUFFER || c == OVL_LOAD_STRING, c == GPIO_BIND_INPUT};
   endfunction
   task automatic dma_cmd(input logic [15:0] c);
      dvalid = 1'b1;
      dword = c;
      chk(ready, 1'b1);
      @(negedge clk);
      dvalid = 1'b0;
      chk(irq, c[15]);
      chk(code, c[15] ? c : m_cmd);
      if (c[15]) begin
         chk({known, async_f, bind_f}, flags(c));
         chk(apply_f, c == SYS_SET_STATE && m_pool[0] == STATE_APPLY_CONFIG);
      end
   endtask
   task automatic finish_cmd(input logic [15:0] c);
      logic [2:0] f;
      logic [14:0] r;
      int n;
      f = flags(c);
      r = ($urandom_range(1) == 0) ? 15'h0000 : 15'($urandom());
      n = 0;
      if (f[2]) begin
         done = 1'b1;
         result = r;
         @(negedge clk);
         done = 1'b0;
      end else begin
         // Unknown codes complete on their own with a failure status
         r = RESULT_BAD_CMD;
         while (irq !== 1'b0 && n < 8) begin
            @(negedge clk);
            n++;
         end
      end
      m_cmd = {1'b0, r};
      chk(irq, 1'b0);
      chk(code, m_cmd);
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      // Bus traffic at full rate needs roughly 78k cycles
      repeat (95000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hcced_753a));
      for (int i = 0; i < 16; i++) m_pool[i] = POOL_RESET;
      m_cmd = CMD_RESET;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(code, CMD_RESET);
      chk({irq, ready, sda_oe, sda_out}, 16'h0004);
      chk(pool_rd, POOL_RESET);
      u_host.probe({SLV_ADDR_HIGH, 1'b0}, ack);
      chk(ack, 1'b0);
      // Strap high moves the slave to its alternate address
      saddr = 1'b1;
      u_host.probe({SLV_ADDR_HIGH, 1'b0}, ack);
      saddr = 1'b0;
      chk(ack, 1'b1);
      // Parameters first, then the command word
      u_host.reg_wr(POOL_ADDR, STATE_APPLY_CONFIG, nk);
      m_pool[0] = STATE_APPLY_CONFIG;
      chk(16'(nk), 16'h0000);
      u_host.reg_wr(CMD_ADDR, SYS_SET_STATE, nk);
      chk(16'(nk), 16'h0000);
      chk(code, SYS_SET_STATE);
      chk({irq, known, apply_f}, 16'h0007);
      // Command write while the doorbell is set leaves the outstanding one alone
      u_host.reg_wr(CMD_ADDR, SYS_GET_STATE, nk);
      chk(16'(nk), 16'h0000);
      chk(code, SYS_SET_STATE);
      chk({irq, known, apply_f}, 16'h0007);
      // Memory sequencer waits while the doorbell is set
      dvalid = 1'b1;
      dword = OVL_FIRST;
      pwe = 1'b1;
      pidx = 4'h1;
      pdata = 16'($urandom());
      m_pool[1] = pdata;
      repeat (3) begin
         @(negedge clk);
         pwe = 1'b0;
         chk(ready, 1'b0);
         chk(code, SYS_SET_STATE);
      end
      done = 1'b1;
      result = 15'h0000;
      @(negedge clk);
      done = 1'b0;
      chk({irq, ready}, 16'h0001);
      chk(code, 16'h0000);
      @(negedge clk);
      dvalid = 1'b0;
      chk(code, OVL_FIRST);
      finish_cmd(OVL_FIRST);
      // Completion pulse with no command outstanding is ignored
      done = 1'b1;
      result = 15'h7FFF;
      @(negedge clk);
      done = 1'b0;
      chk(code, m_cmd);
      // Host polls the doorbell, then fetches response words
      u_host.reg_rd(CMD_ADDR, w0, w1, nk);
      chk(w0, m_cmd);
      chk(w1, RD_UNMAPPED);
      u_host.reg_rd(POOL_ADDR, w0, w1, nk);
      chk(w0, m_pool[0]);
      chk(w1, m_pool[1]);
      chk(16'(nk), 16'h0000);
      repeat (8) begin
         pidx = 4'($urandom_range(15));
         pdata = 16'($urandom());
         pwe = 1'b1;
         m_pool[pidx] = pdata;
         @(negedge clk);
         pwe = 1'b0;
         @(negedge clk);
         chk(pool_rd, m_pool[pidx]);
      end
      // Every decoded code plus neighbours that are not decoded
      codes = '{SYS_SET_STATE, SYS_GET_STATE, 16'h8102, 16'h820F, 16'h8406, 16'h8500};
      for (int c = OVL_FIRST; c <= OVL_LAST; c++) codes.push_back(16'(c));
      for (int c = GPIO_FIRST; c <= GPIO_LAST; c++) codes.push_back(16'(c));
      foreach (codes[i]) begin
         dma_cmd(codes[i]);
         finish_cmd(codes[i]);
      end
      // Word without the doorbell bit is consumed and dropped
      dma_cmd(16'h0100);
      give_verdict();
   end
endmodule // tb_top
